// [ssd_pkg.sv]
// Function
// - Normal operation and applied configuration show the active field pair.
// - Show a waiting message until configuration download is confirmed.
// - Show a transfer message while configuration data is being loaded.
// - Level mode shows signed whole-degree tilt with H and V prefixes.
// - A received ping shows a notice plus the device name.
// - Each diagnostic carries one category letter: F, E, U, I or P.
// - A diagnostic shows its letter first, then its number code.
// - Non-locking errors clear themselves after ten seconds.
// - Automatic clearing never lets the guarded machine restart on its own.
// - A locking error holds until power is removed; nothing clears it.
// - Protective field free for five seconds returns the normal display.
// - Settings blank the display or turn it by 180 degrees.
// - Controller text holds at most 32 ASCII characters.
// - Controller text scrolls for about 40 s, then old content returns.
// - Controller text renders only printable characters of the supported set.
// - A message names its output or diagnosis source with its code.
// - At startup cycle the device facts until the start phase ends.
//
// Shared constants and types of the status display block.
// Assumes one 50 MHz clock for all logic that uses it.
package ssd_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned AUTO_CLEAR_S = 10;
  localparam int unsigned AUTO_CLEAR_CYC = AUTO_CLEAR_S * CLK_HZ;
  localparam int unsigned FIELD_FREE_S = 5;
  localparam int unsigned FIELD_FREE_CYC = FIELD_FREE_S * CLK_HZ;
  localparam int unsigned TEXT_SHOW_S = 40;
  localparam int unsigned TEXT_SHOW_CYC = TEXT_SHOW_S * CLK_HZ;
  localparam int unsigned PING_SHOW_S = 10;
  localparam int unsigned PING_SHOW_CYC = PING_SHOW_S * CLK_HZ;
  localparam int unsigned SCROLL_MS = 300;
  localparam int unsigned SCROLL_CYC = SCROLL_MS * (CLK_HZ / 1000);
  localparam int unsigned START_STEP_MS = 2000;
  localparam int unsigned START_STEP_CYC = START_STEP_MS * (CLK_HZ / 1000);

  ////////////////////////////////////////////////////////////////////////
  // Sizes and record addressing
  localparam int LINE_LEN = 24;
  localparam int TEXT_MAX = 32;
  localparam int NAME_LEN = 16;
  localparam logic [2:0] START_LAST = 3'h5;
  localparam logic [15:0] TEXT_SLOT_MAX = 16'h0001;
  localparam logic [15:0] TEXT_SUBSLOT = 16'h0001;
  localparam logic [15:0] TEXT_INDEX = 16'h70dd;

  ////////////////////////////////////////////////////////////////////////
  // Characters
  localparam logic [7:0] CH_BLANK = 8'h20;
  localparam logic [7:0] CH_FIRST = 8'h21;
  localparam logic [7:0] CH_LAST = 8'h7e;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_DOT = 8'h2e;
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;

  typedef logic [7:0] ssd_char_t;
  typedef ssd_char_t [LINE_LEN-1:0] ssd_line_t;
  typedef ssd_char_t [NAME_LEN-1:0] ssd_name_t;

  typedef enum logic [2:0] {CAT_F, CAT_E, CAT_U, CAT_I, CAT_P} ssd_cat_t;
  typedef enum logic {SRC_GUARD_FIELD, SRC_DEVICE} ssd_src_t;
  typedef enum logic [3:0] {
    VIEW_START, VIEW_LEVEL, VIEW_NORMAL, VIEW_WAIT, VIEW_LOAD,
    VIEW_DIAG, VIEW_PING, VIEW_TEXT
  } ssd_view_t;

  typedef struct packed {
    ssd_cat_t cat;
    logic [9:0] code;
    logic locking;
    ssd_src_t src;
    ssd_char_t chan;
  } ssd_diag_t;

  typedef struct packed {
    logic [15:0] slot;
    logic [15:0] subslot;
    logic [15:0] index;
    logic first;
    logic last;
    ssd_char_t data;
  } ssd_rec_t;

  typedef struct packed {
    logic [4:0] group;
    logic [3:0] set;
    logic [3:0] pair;
  } ssd_pair_t;

  ////////////////////////////////////////////////////////////////////////
  // Fixed texts, first character in the top byte
  localparam logic [4:0][7:0] CAT_CHARS = {"P", "I", "U", "E", "F"};
  localparam ssd_line_t LINE_BLANK = {LINE_LEN{CH_BLANK}};
  localparam ssd_line_t MSG_WAIT = {"WAIT FOR SETUP", {10{CH_BLANK}}};
  localparam ssd_line_t MSG_LOAD = {"SETUP TRANSFER", {10{CH_BLANK}}};
  localparam logic [47:0] TXT_GUARD = "GUARD ";
  localparam logic [47:0] TXT_DEVICE = "DEVICE";
  localparam logic [63:0] TXT_PING = "PING RX ";

endpackage

// [ssd_display.sv]
// Message selection and line buildup for the 24-character status display.
// Assumes all inputs come from logic on clk_i; reset_i stands for power-up.
`timescale 1ns/1ps

module ssd_display
#(
  parameter int unsigned AUTO_CLEAR_CYCLES = ssd_pkg::AUTO_CLEAR_CYC,
  parameter int unsigned FIELD_FREE_CYCLES = ssd_pkg::FIELD_FREE_CYC,
  parameter int unsigned TEXT_SHOW_CYCLES = ssd_pkg::TEXT_SHOW_CYC,
  parameter int unsigned PING_SHOW_CYCLES = ssd_pkg::PING_SHOW_CYC,
  parameter int unsigned SCROLL_CYCLES = ssd_pkg::SCROLL_CYC,
  parameter int unsigned START_STEP_CYCLES = ssd_pkg::START_STEP_CYC
)
(
  input wire logic clk_i, // 50 MHz clock
  input wire logic reset_i, // Async reset, high
  input wire logic started_i, // Start phase over
  input wire ssd_pkg::ssd_line_t info_text_i, // Text of current startup item
  output logic [2:0] startup_item_o, // Startup item being shown
  input wire logic config_ok_i, // Configuration applied
  input wire logic cfg_wait_i, // Waiting for download confirmation
  input wire logic cfg_load_i, // Configuration transfer running
  input wire logic level_mode_i, // Level display requested
  input wire logic signed [7:0] tilt_h_i, // Horizontal tilt, degrees
  input wire logic signed [7:0] tilt_v_i, // Vertical tilt, degrees
  input wire ssd_pkg::ssd_pair_t pair_i, // Active field pair
  input wire logic ping_i, // Identification ping pulse
  input wire ssd_pkg::ssd_name_t name_i, // Device name
  input wire logic diag_valid_i, // New diagnostic pulse
  input wire ssd_pkg::ssd_diag_t diag_i, // Diagnostic record
  input wire logic field_free_i, // Protective field free
  input wire logic restart_ack_i, // Restart acknowledge
  input wire logic rec_valid_i, // Record write byte valid
  input wire ssd_pkg::ssd_rec_t rec_i, // Record write byte
  input wire logic blank_cfg_i, // Setting: display off
  input wire logic rotate_cfg_i, // Setting: turn by 180 degrees
  output ssd_pkg::ssd_line_t line_o, // Characters, leftmost in top byte
  output ssd_pkg::ssd_view_t view_o, // Content shown
  output logic rotate_o, // Glyphs to be drawn turned
  output logic rec_ack_o, // Text taken, pulse
  output logic error_o, // Diagnostic active
  output logic locked_o, // Locking error held
  output logic restart_lock_o, // Machine restart blocked
  output logic auto_clear_o // Error cleared by timeout, pulse
);
  import ssd_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Number formatting

  // Three decimal digits of a code
  function automatic logic [23:0] dec3(input logic [9:0] v);
    logic [9:0] h;
    logic [9:0] t;
    logic [9:0] o;
    h = v / 10'd100;
    t = (v / 10'd10) % 10'd10;
    o = v % 10'd10;
    return {CH_ZERO + h[7:0], CH_ZERO + t[7:0], CH_ZERO + o[7:0]};
  endfunction

  // Sign and two digits of a tilt, clamped at 99
  function automatic logic [23:0] sdeg(input logic signed [7:0] d);
    logic [7:0] m;
    m = (d < 0) ? 8'(-d) : 8'(d);
    if (m > 8'd99)
    begin
      m = 8'd99;
    end
    return {(d < 0) ? CH_MINUS : CH_PLUS, CH_ZERO + m / 8'd10,
            CH_ZERO + m % 8'd10};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Startup item sequencer

  logic [31:0] start_cnt;
  logic [2:0] start_item;
  wire start_step = start_cnt >= START_STEP_CYCLES - 32'd1;

  // Cycle through the startup items while the start phase lasts
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      start_cnt <= '0;
      start_item <= '0;
    end
    else if (started_i || start_step)
    begin
      start_cnt <= '0;
      start_item <= (started_i || start_item == START_LAST) ? 3'h0
                    : start_item + 3'h1;
    end
    else
    begin
      start_cnt <= start_cnt + 32'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Identification ping

  logic ping_on;
  logic [31:0] ping_cnt;
  wire ping_end = ping_cnt >= PING_SHOW_CYCLES - 32'd1;

  // A new ping restarts the notice time
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ping_on <= 1'b0;
      ping_cnt <= '0;
    end
    else if (ping_i)
    begin
      ping_on <= 1'b1;
      ping_cnt <= '0;
    end
    else if (ping_on)
    begin
      ping_on <= !ping_end;
      ping_cnt <= ping_cnt + 32'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Diagnostic record and its clearing

  ssd_diag_t diag;
  logic diag_on;
  logic locked;
  logic restart_lock;
  logic auto_pulse;
  logic [31:0] diag_cnt;
  logic [31:0] free_cnt;
  wire diag_take = diag_valid_i && !locked;
  wire auto_done = diag_cnt >= AUTO_CLEAR_CYCLES - 32'd1;
  wire free_done = free_cnt >= FIELD_FREE_CYCLES - 32'd1;
  wire diag_drop = diag_on && !locked && (auto_done || free_done);
  wire is_fault = diag_i.cat != CAT_I;

  // Store the diagnostic; a locking one is never replaced or cleared
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      diag <= '0;
      diag_on <= 1'b0;
      locked <= 1'b0;
    end
    else if (diag_take)
    begin
      diag <= diag_i;
      diag_on <= 1'b1;
      locked <= diag_i.locking;
    end
    else if (diag_drop)
    begin
      diag_on <= 1'b0;
    end
  end

  // Time the error and the free field
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      diag_cnt <= '0;
      free_cnt <= '0;
      auto_pulse <= 1'b0;
    end
    else
    begin
      diag_cnt <= (diag_take || !diag_on || locked) ? 32'd0 : diag_cnt + 32'd1;
      free_cnt <= (field_free_i && diag_on && !diag_take) ? free_cnt + 32'd1 : 32'd0;
      auto_pulse <= diag_drop && auto_done && !diag_take;
    end
  end

  // Restart stays blocked after an automatic clear until acknowledged
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      restart_lock <= 1'b0;
    end
    else if (diag_take && is_fault)
    begin
      restart_lock <= 1'b1;
    end
    else if (restart_ack_i && !diag_on && !locked)
    begin
      restart_lock <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Controller text reception

  ssd_char_t [TEXT_MAX-1:0] text_buf;
  logic [5:0] wr_ptr;
  logic text_on;
  logic [31:0] text_cnt;
  logic [31:0] scroll_cnt;
  logic [4:0] scroll_off;
  logic ack;
  wire rec_hit = rec_valid_i && rec_i.slot <= TEXT_SLOT_MAX
                 && rec_i.subslot == TEXT_SUBSLOT
                 && rec_i.index == TEXT_INDEX;
  wire [5:0] wr_at = rec_i.first ? 6'd0 : wr_ptr;
  wire printable = rec_i.data >= CH_FIRST && rec_i.data <= CH_LAST;
  wire ssd_char_t filt = printable ? rec_i.data : CH_BLANK;
  wire text_end = text_cnt >= TEXT_SHOW_CYCLES - 32'd1;
  wire scroll_step = scroll_cnt >= SCROLL_CYCLES - 32'd1;
  wire text_go = rec_hit && rec_i.last;

  // Fill the buffer; a first byte blanks the rest, bytes past 32 drop
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      text_buf <= {TEXT_MAX{CH_BLANK}};
      wr_ptr <= '0;
    end
    else if (rec_hit)
    begin
      for (int i = 0; i < TEXT_MAX; i++)
      begin
        if (6'(i) == wr_at)
        begin
          text_buf[i] <= filt;
        end
        else if (rec_i.first)
        begin
          text_buf[i] <= CH_BLANK;
        end
      end
      wr_ptr <= (wr_at == 6'(TEXT_MAX)) ? wr_at : wr_at + 6'd1;
    end
  end

  // Show the text for its time, stepping the scroll window
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      text_on <= 1'b0;
      text_cnt <= '0;
      scroll_cnt <= '0;
      scroll_off <= '0;
      ack <= 1'b0;
    end
    else
    begin
      ack <= text_go;
      if (text_go)
      begin
        text_on <= 1'b1;
        text_cnt <= '0;
        scroll_cnt <= '0;
        scroll_off <= '0;
      end
      else if (text_on)
      begin
        text_on <= !text_end;
        text_cnt <= text_cnt + 32'd1;
        scroll_cnt <= scroll_step ? 32'd0 : scroll_cnt + 32'd1;
        scroll_off <= scroll_step ? scroll_off + 5'd1 : scroll_off;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Content selection

  ssd_view_t next_view;
  ssd_view_t view;

  // Highest priority first; text ends back in whatever lies below it
  always_comb
  begin
    if (locked)
    begin
      next_view = VIEW_DIAG;
    end
    else if (text_on)
    begin
      next_view = VIEW_TEXT;
    end
    else if (ping_on)
    begin
      next_view = VIEW_PING;
    end
    else if (diag_on)
    begin
      next_view = VIEW_DIAG;
    end
    else if (cfg_load_i)
    begin
      next_view = VIEW_LOAD;
    end
    else if (cfg_wait_i)
    begin
      next_view = VIEW_WAIT;
    end
    else if (!started_i)
    begin
      next_view = VIEW_START;
    end
    else if (level_mode_i || !config_ok_i)
    begin
      next_view = VIEW_LEVEL;
    end
    else
    begin
      next_view = VIEW_NORMAL;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Line buildup

  wire ssd_line_t text_win;
  ssd_line_t next_line;
  wire ssd_line_t turned;
  wire [47:0] src_txt = (diag.src == SRC_GUARD_FIELD) ? TXT_GUARD : TXT_DEVICE;

  // Scroll window over the text buffer and the turned line
  for (genvar g = 0; g < LINE_LEN; g++)
  begin : g_pos
    wire [4:0] idx = scroll_off + 5'(g);
    assign text_win[LINE_LEN-1-g] = text_buf[idx];
    assign turned[g] = next_line[LINE_LEN-1-g];
  end

  // Compose the characters of the chosen content
  always_comb
  begin
    case (next_view)
      VIEW_START: next_line = info_text_i;
      VIEW_WAIT: next_line = MSG_WAIT;
      VIEW_LOAD: next_line = MSG_LOAD;
      VIEW_LEVEL: next_line = {"H", sdeg(tilt_h_i), " V", sdeg(tilt_v_i),
                               {15{CH_BLANK}}};
      VIEW_PING: next_line = {TXT_PING, name_i};
      VIEW_DIAG: next_line = {src_txt, CH_BLANK, diag.chan, ": ",
                              CAT_CHARS[diag.cat], dec3(diag.code),
                              {10{CH_BLANK}}};
      VIEW_TEXT: next_line = text_win;
      default: next_line = {CH_A + 8'(pair_i.group), CH_ZERO + 8'(pair_i.set),
                            CH_DOT, CH_ZERO + 8'(pair_i.pair),
                            {20{CH_BLANK}}};
    endcase
  end

  // Register the shown line with the display settings applied
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      line_o <= LINE_BLANK;
      view <= VIEW_START;
      rotate_o <= 1'b0;
    end
    else
    begin
      line_o <= blank_cfg_i ? LINE_BLANK
                : (rotate_cfg_i ? turned : next_line);
      view <= next_view;
      rotate_o <= rotate_cfg_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status outputs
  assign view_o = view;
  assign startup_item_o = start_item;
  assign rec_ack_o = ack;
  assign error_o = diag_on;
  assign locked_o = locked;
  assign restart_lock_o = restart_lock;
  assign auto_clear_o = auto_pulse;

endmodule

// [ssd_ctrl_model.sv]
// Model of the safety controller that writes display text records.
// Assumes the bench raises go_i for one cycle while busy_o is low.
`timescale 1ns/1ps

module ssd_ctrl_model
(
  input wire logic clk_i, // Clock
  input wire logic go_i, // Start one record write
  input wire logic [15:0] slot_i, // Target slot
  input wire logic [7:0] len_i, // Byte count
  input wire logic [7:0] gap_i, // Idle cycles before each byte
  input wire logic [255:0] text_i, // Text, last byte in bits 7:0
  output logic busy_o, // Write running
  output logic rec_valid_o, // Byte valid
  output ssd_pkg::ssd_rec_t rec_o // Byte and its addressing
);
  import ssd_pkg::*;

  // Idle state at time zero
  initial
  begin
    busy_o = 1'b0;
    rec_valid_o = 1'b0;
    rec_o = '0;
  end

  // Bytes change on falling edges; idle data toggles so a stale byte never looks settled
  always @(posedge go_i)
  begin
    busy_o = 1'b1;
    for (int k = 0; k < len_i; k++)
    begin
      repeat (gap_i)
      begin
        @(negedge clk_i);
        rec_valid_o = 1'b0;
        rec_o.data = ~rec_o.data;
      end
      @(negedge clk_i);
      rec_o.slot = slot_i;
      rec_o.subslot = TEXT_SUBSLOT;
      rec_o.index = TEXT_INDEX;
      rec_o.first = (k == 0);
      rec_o.last = (k == len_i - 1);
      rec_o.data = text_i[8*(len_i-1-k) +: 8];
      rec_valid_o = 1'b1;
    end
    @(negedge clk_i);
    rec_valid_o = 1'b0;
    rec_o.data = ~rec_o.data;
    busy_o = 1'b0;
  end
endmodule

// [ssd_display_chk.sv]
// Port checker for the status display block.
// Assumes it is bound onto ssd_display; one clock, async high reset.
`timescale 1ns/1ps

module ssd_display_chk
(
  input wire logic clk_i, // Clock
  input wire logic reset_i, // Async reset, high
  input wire logic diag_valid_i, // New diagnostic pulse
  input wire ssd_pkg::ssd_diag_t diag_i, // Diagnostic record
  input wire logic restart_ack_i, // Restart acknowledge
  input wire logic rec_valid_i, // Record byte valid
  input wire ssd_pkg::ssd_rec_t rec_i, // Record byte
  input wire logic blank_cfg_i, // Display off setting
  input wire ssd_pkg::ssd_line_t line_o, // Shown line
  input wire ssd_pkg::ssd_view_t view_o, // Content shown
  input wire logic rec_ack_o, // Text taken
  input wire logic error_o, // Diagnostic held
  input wire logic locked_o, // Locking error held
  input wire logic restart_lock_o, // Restart blocked
  input wire logic auto_clear_o // Timeout clear pulse
);
  import ssd_pkg::*;

  logic addr_ok;

  // Record write addressed to the text record
  assign addr_ok = rec_i.slot <= TEXT_SLOT_MAX && rec_i.subslot == TEXT_SUBSLOT &&
    rec_i.index == TEXT_INDEX;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  ////////////////////////////////////////////////////////////////////////
  // Diagnostics
  diag_take_a: assert property (diag_valid_i && !locked_o |=> error_o)
    else $error("diagnostic not taken");
  lock_take_a: assert property (diag_valid_i && !locked_o && diag_i.locking |=> locked_o)
    else $error("locking error not held");
  lock_hold_a: assert property (locked_o |=> locked_o && error_o)
    else $error("locking error released");
  lock_noclear_a: assert property (locked_o |-> !auto_clear_o)
    else $error("locking error cleared by timeout");
  auto_clear_a: assert property (auto_clear_o |-> !error_o && $past(error_o))
    else $error("timeout clear without held error");
  restart_set_a: assert property (diag_valid_i && !locked_o && diag_i.cat != CAT_I
    |=> restart_lock_o)
    else $error("restart not blocked");
  restart_free_a: assert property ($fell(restart_lock_o) |->
    $past(restart_ack_i) && !$past(error_o))
    else $error("restart released without acknowledge");

  ////////////////////////////////////////////////////////////////////////
  // Text records and settings
  text_ack_a: assert property (rec_valid_i && rec_i.last && addr_ok && !locked_o
    |=> rec_ack_o ##1 view_o == VIEW_TEXT)
    else $error("text record not shown");
  text_refuse_a: assert property (rec_valid_i && !addr_ok |=> !rec_ack_o)
    else $error("misaddressed record taken");
  blank_line_a: assert property (blank_cfg_i |=> line_o == LINE_BLANK)
    else $error("blank setting ignored");

  // Main scenarios reached
  text_seen_c: cover property (rec_ack_o);
  auto_seen_c: cover property (auto_clear_o);
  lock_seen_c: cover property ($rose(locked_o));
  ping_seen_c: cover property (view_o == VIEW_PING);
endmodule

bind ssd_display ssd_display_chk chk_u (.clk_i(clk_i), .reset_i(reset_i),
  .diag_valid_i(diag_valid_i), .diag_i(diag_i), .restart_ack_i(restart_ack_i),
  .rec_valid_i(rec_valid_i), .rec_i(rec_i), .blank_cfg_i(blank_cfg_i), .line_o(line_o),
  .view_o(view_o), .rec_ack_o(rec_ack_o), .error_o(error_o), .locked_o(locked_o),
  .restart_lock_o(restart_lock_o), .auto_clear_o(auto_clear_o));

// [tb_top.sv]
// Self-checking bench for the status display block.
// Assumes short timer parameters; controller model drives record writes.
`timescale 1ns/1ps

module tb_top;
  import ssd_pkg::*;

  logic clk_i = 1'b0, reset_i = 1'b1, started_i = 1'b0, config_ok_i = 1'b0;
  logic cfg_wait_i = 1'b0, cfg_load_i = 1'b0, level_mode_i = 1'b0, ping_i = 1'b0;
  logic diag_valid_i = 1'b0, field_free_i = 1'b0, restart_ack_i = 1'b0;
  logic blank_cfg_i = 1'b0, rotate_cfg_i = 1'b0, go = 1'b0, busy, rec_valid_i;
  logic [15:0] slot = 16'h0;
  logic [7:0] len = 8'h1, gap = 8'h0;
  logic [255:0] text = '0;
  ssd_diag_t diag_i = '0;
  ssd_rec_t rec_i;
  ssd_name_t name_i = "SCANNER NORTH 01";
  ssd_line_t info_text = LINE_BLANK;
  logic signed [7:0] tilt_h = -8'sd3, tilt_v = 8'sd9;
  ssd_pair_t pair = 13'h0011;
  ssd_line_t line_o;
  ssd_view_t view_o;
  logic [2:0] startup_item_o;
  logic rotate_o, rec_ack_o, error_o, locked_o, restart_lock_o, auto_clear_o, got;
  int num_errors = 0, total_checks = 0;

  // Clock of 20 ns
  always #10 clk_i = ~clk_i;

  ssd_display #(.AUTO_CLEAR_CYCLES(50), .FIELD_FREE_CYCLES(20), .TEXT_SHOW_CYCLES(200),
    .PING_SHOW_CYCLES(30), .SCROLL_CYCLES(5), .START_STEP_CYCLES(10)) dut_u (
    .clk_i(clk_i), .reset_i(reset_i), .started_i(started_i), .info_text_i(info_text),
    .startup_item_o(startup_item_o), .config_ok_i(config_ok_i), .cfg_wait_i(cfg_wait_i),
    .cfg_load_i(cfg_load_i), .level_mode_i(level_mode_i), .tilt_h_i(tilt_h),
    .tilt_v_i(tilt_v), .pair_i(pair), .ping_i(ping_i), .name_i(name_i),
    .diag_valid_i(diag_valid_i), .diag_i(diag_i), .field_free_i(field_free_i),
    .restart_ack_i(restart_ack_i), .rec_valid_i(rec_valid_i), .rec_i(rec_i),
    .blank_cfg_i(blank_cfg_i), .rotate_cfg_i(rotate_cfg_i), .line_o(line_o),
    .view_o(view_o), .rotate_o(rotate_o), .rec_ack_o(rec_ack_o), .error_o(error_o),
    .locked_o(locked_o), .restart_lock_o(restart_lock_o), .auto_clear_o(auto_clear_o));

  ssd_ctrl_model ctrl_u (.clk_i(clk_i), .go_i(go), .slot_i(slot), .len_i(len),
    .gap_i(gap), .text_i(text), .busy_o(busy), .rec_valid_o(rec_valid_i), .rec_o(rec_i));

  ////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic step(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic check(input logic [199:0] seen, input logic [199:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  function automatic ssd_line_t diag_line(input int c, input ssd_src_t s);
    return {(s == SRC_DEVICE) ? TXT_DEVICE : TXT_GUARD, " A: ", CAT_CHARS[c], "123",
      {10{CH_BLANK}}};
  endfunction

  task automatic pulse_diag(input ssd_cat_t c, input logic lock, input ssd_src_t s);
    diag_i = '{cat: c, code: 10'd123, locking: lock, src: s, chan: "A"};
    diag_valid_i = 1'b1;
    step(1);
    diag_valid_i = 1'b0;
    step(2);
  endtask

  // Runs one record write, notes the acknowledge and the line then shown
  task automatic send(input logic [15:0] s, input int n, input int g, input logic [255:0] t,
    input logic exp_ack, input ssd_line_t exp_line);
    got = 1'b0;
    {slot, len, gap, text} = {s, n[7:0], g[7:0], t};
    go = 1'b1;
    step(1);
    go = 1'b0;
    for (int i = 0; i < n * (g + 1) + 4; i++)
    begin
      step(1);
      if (rec_ack_o === 1'b1)
      begin
        got = 1'b1;
        step(1); // Shown line follows the pulse by one cycle
        check(line_o, exp_line);
        check(view_o, VIEW_TEXT);
      end
    end
    check(got, exp_ack);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_start_cfg();
    check(view_o, VIEW_START);
    info_text = {"SELF TEST", {15{CH_BLANK}}};
    got = 1'b0;
    for (int i = 0; i < 15 && !got; i++)
    begin
      step(1);
      got = (startup_item_o === 3'h1);
    end
    check(got, 1'b1);
    check(line_o, info_text);
    started_i = 1'b1;
    step(2);
    check({view_o, line_o}, {VIEW_LEVEL, "H-03 V+09", {15{CH_BLANK}}});
    cfg_wait_i = 1'b1;
    step(2);
    check({view_o, line_o}, {VIEW_WAIT, MSG_WAIT});
    {cfg_wait_i, cfg_load_i} = 2'b01;
    step(2);
    check({view_o, line_o}, {VIEW_LOAD, MSG_LOAD});
    {cfg_load_i, config_ok_i} = 2'b01;
    step(2);
    check({view_o, line_o}, {VIEW_NORMAL, "A1.1", {20{CH_BLANK}}});
    {level_mode_i, tilt_h, tilt_v} = {1'b1, 8'sd12, -8'sd120};
    step(2);
    check({view_o, line_o}, {VIEW_LEVEL, "H+12 V-99", {15{CH_BLANK}}});
    level_mode_i = 1'b0;
    step(2);
  endtask

  task automatic t_diag();
    for (int c = 0; c < 5; c++)
    begin
      pulse_diag(ssd_cat_t'(c), 1'b0, ssd_src_t'(c % 2));
      check({view_o, line_o}, {VIEW_DIAG, diag_line(c, ssd_src_t'(c % 2))});
    end
    step(38);
    check(error_o, 1'b1);
    got = 1'b0;
    for (int i = 0; i < 20 && !got; i++)
    begin
      step(1);
      got = auto_clear_o;
    end
    check({got, error_o, restart_lock_o}, 3'b101);
    restart_ack_i = 1'b1;
    step(1);
    restart_ack_i = 1'b0;
    step(2);
    check(restart_lock_o, 1'b0);
    pulse_diag(CAT_U, 1'b0, SRC_GUARD_FIELD);
    field_free_i = 1'b1;
    step(14);
    check(error_o, 1'b1);
    for (int i = 0; i < 15 && error_o; i++) step(1);
    step(1);
    check({error_o, view_o}, {1'b0, VIEW_NORMAL});
    field_free_i = 1'b0;
  endtask

  task automatic t_ping_text();
    ping_i = 1'b1;
    step(1);
    ping_i = 1'b0;
    step(2);
    check({view_o, line_o}, {VIEW_PING, TXT_PING, name_i});
    for (int i = 0; i < 40 && view_o == VIEW_PING; i++) step(1);
    send(16'h0, 4, 0, {"AB", 8'h01, "z"}, 1'b1, {"AB z", {20{CH_BLANK}}});
    send(16'h2, 2, 0, "NO", 1'b0, LINE_BLANK);
    send(16'h1, 2, 3, "OK", 1'b1, {"OK", {22{CH_BLANK}}});
    for (int i = 0; i < 260 && view_o == VIEW_TEXT; i++) step(1);
    check(view_o, VIEW_NORMAL);
  endtask

  task automatic t_settings();
    cfg_wait_i = 1'b1;
    rotate_cfg_i = 1'b1;
    step(3);
    check(rotate_o, 1'b1);
    for (int k = 0; k < LINE_LEN; k++) check(line_o[k], MSG_WAIT[LINE_LEN-1-k]);
    blank_cfg_i = 1'b1;
    step(3);
    check(line_o, LINE_BLANK);
    {cfg_wait_i, rotate_cfg_i, blank_cfg_i} = 3'b000;
    step(2);
  endtask

  task automatic t_lock();
    pulse_diag(CAT_F, 1'b1, SRC_GUARD_FIELD);
    field_free_i = 1'b1;
    step(80);
    pulse_diag(CAT_I, 1'b0, SRC_DEVICE);
    check({locked_o, error_o, line_o}, {2'b11, diag_line(0, SRC_GUARD_FIELD)});
    reset_i = 1'b1;
    step(2);
    check({locked_o, error_o, view_o, line_o}, {2'b00, VIEW_START, LINE_BLANK});
    reset_i = 1'b0;
    field_free_i = 1'b0;
    step(2);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Verdict and run control
  task automatic results();
    if (num_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(posedge clk_i);
    step(1);
    reset_i = 1'b0;
    t_start_cfg();
    t_diag();
    t_ping_text();
    t_settings();
    t_lock();
    results();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    results();
  end
endmodule
